// ### design/crst_params.svh
// Register map, field positions and reset values of the card reset block
`ifndef CRST_PARAMS_SVH
`define CRST_PARAMS_SVH

`define CRST_ADDR_SUPCTL 16'hFE03
`define CRST_ADDR_SIGCTL 16'hFE0A
`define CRST_ADDR_BYTECTL 16'hFE12
`define CRST_ADDR_INITIAL_CHAR_TIMEOUT_VALUE 16'hFE21
`define CRST_ADDR_RLEN 16'hFE22
`define CRST_ADDR_FLTCTL 16'hFFD4
`define CRST_ADDR_IRQSTAT 16'hFE40
`define CRST_ADDR_IRQEN 16'hFE41
`define CRST_ADDR_IRQCLR 16'hFE42

`define CRST_BIT_HOLD 7
`define CRST_BIT_DETEN 6
`define CRST_BIT_OVRD 6
`define CRST_BIT_FLTDIS 5
`define CRST_BIT_FLTSTAT 5
`define CRST_BIT_SUPOK 3
`define CRST_BIT_EV_TS 0
`define CRST_BIT_EV_FLT 1

`define CRST_RST_INITIAL_CHAR_TIMEOUT_VALUE 8'h00
`define CRST_RST_RLEN 8'h70
`define CRST_RST_FLTCTL 8'h00
`define CRST_RST_CTL 8'h00
`define CRST_FLTCTL_MASK 8'h67

`endif

// ### design/crst_pkg.sv
// Types shared by the card reset block
package crst_pkg;
    typedef enum logic [1:0] {
        ST_HOLD,
        ST_DELAY,
        ST_REL
    } crst_state_e;
    typedef logic [7:0] crst_byte_t;
    typedef logic [1:0] crst_ev_t;
endpackage

// ### design/crst_tmr_if.sv
// Control bundle between the sequencer and one ETU timer
interface crst_tmr_if;
    logic en;
    logic tick;
    logic start;
    logic stop;
    logic [7:0] limit;
    logic expire;
    logic busy;
    modport ctrl (output en, output tick, output start, output stop, output limit,
                  input expire, input busy);
    modport tmr (input en, input tick, input start, input stop, input limit,
                 output expire, output busy);
endinterface

// ### design/crst_etu_timer.sv
// ETU counting timer with a one-cycle expiry pulse
module crst_etu_timer #(
    parameter bit INCLUSIVE = 1'b0
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    crst_tmr_if.tmr t
);
    logic [7:0] cnt_q;
    logic [7:0] lim_q;
    logic busy_q;
    logic expire_q;
    logic last;

    // Inclusive mode fires only once the limit is exceeded, not reached
    assign last = INCLUSIVE ? (cnt_q == lim_q) : (8'(cnt_q + 8'h01) == lim_q);
    assign t.busy = busy_q;
    assign t.expire = expire_q;

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cnt_q <= 8'h00;
            lim_q <= 8'h00;
            busy_q <= 1'b0;
            expire_q <= 1'b0;
        end
        else if (t.en)
        begin
            expire_q <= 1'b0;
            if (t.start)
            begin
                busy_q <= 1'b1;
                cnt_q <= 8'h00;
                lim_q <= t.limit;
            end
            else if (t.stop)
            begin
                busy_q <= 1'b0;
            end
            else if (busy_q && t.tick)
            begin
                if (last)
                begin
                    busy_q <= 1'b0;
                    expire_q <= 1'b1;
                end
                else
                begin
                    cnt_q <= 8'(cnt_q + 8'h01);
                end
            end
        end
    end

    property p_tick_only;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        t.en && !t.tick && !t.start |=> $stable(cnt_q);
    endproperty
    a_tick_only: assert property (p_tick_only)
        else $error("ETU counter moved without a tick");
endmodule

// ### design/crst_top.sv
// Card reset sequencing, answer-to-reset start timing and core supply fault supervision
//
// The implementer's own choice: the strobed register port.
`include "crst_params.svh"

// Behaviour
// - Detect enable measures release-to-first-character ETUs, limit 8-bit
// - Initial-character timer starts at reset release
// - Late first character raises mute-card timeout
// - Release delayed by reset-length ETUs, default 0x70
// - Zero length, no hold: release on supply good
// - Hold bit drives card reset low
// - Clearing hold releases after reset-length delay
// - Hold before power-up keeps card in reset
// - Enabled low supply deactivates card interface
// - Override bit selects threshold from field
// - Override clear uses factory default threshold
// - Fault-disable bit turns supervision off
// - Codes 000-111 map 2.3V to 3.0V
// - Initial-character timer timeout raises firmware interrupt
module crst_top
    import crst_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic etu_tick_i,
    input wire logic first_char_edge_i,
    input wire logic card_supply_good_i,
    input wire logic [7:0] vdd_below_i,
    input wire logic [2:0] fuse_thr_i,
    output logic card_reset_n_o,
    output logic card_deactivate_o,
    output logic [2:0] fault_threshold_o,
    output logic irq_o
);
    crst_state_e state_q;
    crst_state_e state_d;
    crst_byte_t sigctl_q;
    crst_byte_t bytectl_q;
    crst_byte_t initial_char_timeout_value_q;
    crst_byte_t rlen_q;
    crst_byte_t fltctl_q;
    crst_byte_t rdata_q;
    crst_ev_t status_q;
    crst_ev_t irq_en_q;
    crst_ev_t ev;
    crst_ev_t clr;
    logic [1:0] sup_sync_q;
    logic [7:0] low_meta_q;
    logic [7:0] low_q;
    logic [2:0] fuse_q;
    logic fuse_done_q;
    logic [2:0] thr_q;
    logic deact_q;
    logic fault_cond;
    logic sup_ok;
    logic hold;
    logic det_en;
    logic rel_start;

    crst_tmr_if rd_t ();
    crst_tmr_if ts_t ();

    assign sup_ok = sup_sync_q[1];
    assign hold = sigctl_q[`CRST_BIT_HOLD];
    assign det_en = bytectl_q[`CRST_BIT_DETEN];

    // Card supply good is a comparator level from the analog side
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sup_sync_q <= 2'b00;
            low_meta_q <= 8'h00;
            low_q <= 8'h00;
        end
        else if (clk_en_i)
        begin
            sup_sync_q <= {sup_sync_q[0], card_supply_good_i};
            low_meta_q <= vdd_below_i;
            low_q <= low_meta_q;
        end
    end

    // Fuses are caught once after release; reset itself may only load constants
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            fuse_q <= 3'h0;
            fuse_done_q <= 1'b0;
        end
        else if (clk_en_i && !fuse_done_q)
        begin
            fuse_q <= fuse_thr_i;
            fuse_done_q <= 1'b1;
        end
    end

    // Threshold code n selects comparator n: 2.3V plus n times 0.1V
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            thr_q <= 3'h0;
        end
        else if (clk_en_i)
        begin
            if (fltctl_q[`CRST_BIT_OVRD])
            begin
                thr_q <= fltctl_q[2:0];
            end
            else
            begin
                thr_q <= fuse_q;
            end
        end
    end

    assign fault_threshold_o = thr_q;
    assign fault_cond = !fltctl_q[`CRST_BIT_FLTDIS] && low_q[thr_q];

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            deact_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            deact_q <= fault_cond;
        end
    end

    assign card_deactivate_o = deact_q;

    // Reset sequencing; a supply loss or fault always returns to hold
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_HOLD:
            begin
                if (sup_ok && !hold && !deact_q)
                begin
                    state_d = (rlen_q == 8'h00) ? ST_REL : ST_DELAY;
                end
            end
            ST_DELAY:
            begin
                if (hold || !sup_ok || deact_q)
                begin
                    state_d = ST_HOLD;
                end
                else if (rd_t.expire)
                begin
                    state_d = ST_REL;
                end
            end
            ST_REL:
            begin
                if (hold || !sup_ok || deact_q)
                begin
                    state_d = ST_HOLD;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_q <= ST_HOLD;
        end
        else if (clk_en_i)
        begin
            state_q <= state_d;
        end
    end

    assign card_reset_n_o = (state_q == ST_REL);
    assign rel_start = (state_q != ST_REL) && (state_d == ST_REL);

    assign rd_t.en = clk_en_i;
    assign rd_t.tick = etu_tick_i;
    assign rd_t.start = (state_q == ST_HOLD) && (state_d == ST_DELAY);
    assign rd_t.stop = (state_d != ST_DELAY);
    assign rd_t.limit = rlen_q;

    assign ts_t.en = clk_en_i;
    assign ts_t.tick = etu_tick_i;
    assign ts_t.start = rel_start && det_en;
    assign ts_t.stop = first_char_edge_i || (state_d != ST_REL);
    assign ts_t.limit = initial_char_timeout_value_q;

    crst_etu_timer #(.INCLUSIVE(1'b0)) u_rlen_tmr (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .t(rd_t)
    );

    // Limit counts as allowed ETUs, so a timeout means it was exceeded
    crst_etu_timer #(.INCLUSIVE(1'b1)) u_ts_tmr (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .t(ts_t)
    );

    assign ev[`CRST_BIT_EV_TS] = ts_t.expire;
    assign ev[`CRST_BIT_EV_FLT] = fault_cond && !deact_q;
    assign clr = (wr_i && addr_i == `CRST_ADDR_IRQCLR) ? wdata_i[1:0] : 2'b00;

    // A new event in the clear cycle survives the clear
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            status_q <= 2'b00;
        end
        else if (clk_en_i)
        begin
            status_q <= (status_q & ~clr) | ev;
        end
    end

    assign irq_o = |(status_q & irq_en_q);

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sigctl_q <= `CRST_RST_CTL;
            bytectl_q <= `CRST_RST_CTL;
            initial_char_timeout_value_q <= `CRST_RST_INITIAL_CHAR_TIMEOUT_VALUE;
            rlen_q <= `CRST_RST_RLEN;
            fltctl_q <= `CRST_RST_FLTCTL;
            irq_en_q <= 2'b00;
        end
        else if (clk_en_i && wr_i)
        begin
            unique case (addr_i)
                `CRST_ADDR_SIGCTL: sigctl_q <= wdata_i;
                `CRST_ADDR_BYTECTL: bytectl_q <= wdata_i;
                `CRST_ADDR_INITIAL_CHAR_TIMEOUT_VALUE: initial_char_timeout_value_q <= wdata_i;
                `CRST_ADDR_RLEN: rlen_q <= wdata_i;
                `CRST_ADDR_FLTCTL: fltctl_q <= wdata_i & `CRST_FLTCTL_MASK;
                `CRST_ADDR_IRQEN: irq_en_q <= wdata_i[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_q <= 8'h00;
        end
        else if (clk_en_i)
        begin
            rdata_q <= 8'h00;
            if (rd_i)
            begin
                unique case (addr_i)
                    `CRST_ADDR_SUPCTL: rdata_q <= {2'b00, deact_q, 1'b0, sup_ok, 3'b000};
                    `CRST_ADDR_SIGCTL: rdata_q <= sigctl_q;
                    `CRST_ADDR_BYTECTL: rdata_q <= bytectl_q;
                    `CRST_ADDR_INITIAL_CHAR_TIMEOUT_VALUE: rdata_q <= initial_char_timeout_value_q;
                    `CRST_ADDR_RLEN: rdata_q <= rlen_q;
                    `CRST_ADDR_FLTCTL: rdata_q <= fltctl_q;
                    `CRST_ADDR_IRQSTAT: rdata_q <= {6'h00, status_q};
                    `CRST_ADDR_IRQEN: rdata_q <= {6'h00, irq_en_q};
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign rdata_o = rdata_q;

    property p_hold_low;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        clk_en_i && hold |=> !card_reset_n_o;
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("Card reset released while hold bit set");

    property p_zero_len;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        clk_en_i && state_q == ST_HOLD && sup_ok && !hold && !deact_q && rlen_q == 8'h00
            |=> card_reset_n_o;
    endproperty
    a_zero_len: assert property (p_zero_len)
        else $error("Zero length did not release at once");

    property p_delay_release;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(card_reset_n_o) && $past(state_q) == ST_DELAY |-> $past(rd_t.expire);
    endproperty
    a_delay_release: assert property (p_delay_release)
        else $error("Release before reset length elapsed");

    property p_nonzero_waits;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        clk_en_i && state_q == ST_HOLD && rlen_q != 8'h00 |=> !card_reset_n_o;
    endproperty
    a_nonzero_waits: assert property (p_nonzero_waits)
        else $error("Nonzero length released without delay");

    property p_release_needs_clear;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(card_reset_n_o) |-> !$past(hold) && $past(sup_ok);
    endproperty
    a_release_needs_clear: assert property (p_release_needs_clear)
        else $error("Release while held or unpowered");

    property p_ts_start;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        clk_en_i && rel_start && det_en && !first_char_edge_i |=> ts_t.busy;
    endproperty
    a_ts_start: assert property (p_ts_start)
        else $error("Initial character timer not started at release");

    property p_ts_flag;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        clk_en_i && ts_t.expire |=> status_q[`CRST_BIT_EV_TS];
    endproperty
    a_ts_flag: assert property (p_ts_flag)
        else $error("Initial character timeout not flagged");

    property p_fault_deact;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        clk_en_i && fault_cond |=> card_deactivate_o ##1 (!$past(clk_en_i) || !card_reset_n_o);
    endproperty
    a_fault_deact: assert property (p_fault_deact)
        else $error("Supply fault did not deactivate card");

    property p_fault_off;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        clk_en_i && fltctl_q[`CRST_BIT_FLTDIS] |=> !card_deactivate_o;
    endproperty
    a_fault_off: assert property (p_fault_off)
        else $error("Deactivation while fault detection disabled");

    property p_thr_sel;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        clk_en_i |=> fault_threshold_o ==
            ($past(fltctl_q[`CRST_BIT_OVRD]) ? $past(fltctl_q[2:0]) : $past(fuse_q));
    endproperty
    a_thr_sel: assert property (p_thr_sel)
        else $error("Wrong fault threshold source");

    // An enabled event must reach the pin unless the enable is being rewritten
    property p_irq;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        clk_en_i && |(ev & irq_en_q) && !(wr_i && addr_i == `CRST_ADDR_IRQEN) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt output disagrees with status");

    c_release: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(card_reset_n_o) && $past(state_q) == ST_DELAY);
    c_ts_timeout: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) ts_t.expire);
    c_fault: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) $rose(deact_q));
endmodule

// ### dv/crst_card_model.sv
// Behavioural smart card that answers a reset release with a first character
module crst_card_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic card_reset_n_i,
    input wire logic etu_tick_i,
    input wire logic mute_i,
    input wire logic [7:0] delay_i,
    output logic first_char_edge_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q;
    logic done_q;
    // Counts ETUs from release; a mute card never answers, as a dead card would not
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cnt_q <= 8'h00;
            done_q <= 1'b0;
            first_char_edge_o <= 1'b0;
        end
        else
        begin
            first_char_edge_o <= 1'b0;
            if (!card_reset_n_i)
            begin
                cnt_q <= 8'h00;
                done_q <= 1'b0;
            end
            else if (etu_tick_i && !done_q)
            begin
                cnt_q <= cnt_q + 8'h01;
                if (cnt_q + 8'h01 == delay_i && !mute_i)
                begin
                    first_char_edge_o <= 1'b1;
                    done_q <= 1'b1;
                end
            end
        end
    end
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the card reset block
`include "crst_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import crst_pkg::*;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic etu_tick_i = 1'b0;
    logic card_supply_good_i = 1'b0;
    logic [7:0] vdd_below_i = 8'h00;
    logic [2:0] fuse_thr_i = 3'h0;
    logic [7:0] rdata_o;
    logic first_char_edge_i;
    logic card_reset_n_o;
    logic card_deactivate_o;
    logic [2:0] fault_threshold_o;
    logic irq_o;
    logic card_mute = 1'b0;
    logic [7:0] card_delay = 8'h01;
    logic rd_p = 1'b0;
    crst_byte_t exp_q[$];
    int num_errors = 0;
    int tests_run = 0;

    always #50 sys_clk_i = ~sys_clk_i;

    crst_top dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .etu_tick_i(etu_tick_i), .first_char_edge_i(first_char_edge_i),
        .card_supply_good_i(card_supply_good_i), .vdd_below_i(vdd_below_i),
        .fuse_thr_i(fuse_thr_i), .card_reset_n_o(card_reset_n_o),
        .card_deactivate_o(card_deactivate_o), .fault_threshold_o(fault_threshold_o),
        .irq_o(irq_o));

    crst_card_model card (.clk_i(sys_clk_i), .resetn_i(resetn_i),
        .card_reset_n_i(card_reset_n_o), .etu_tick_i(etu_tick_i), .mute_i(card_mute),
        .delay_i(card_delay), .first_char_edge_o(first_char_edge_i));

    task automatic fail(input string m);
        num_errors++;
        $display("mismatch at %0t: %s", $time, m);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        tests_run++;
        if (got !== exp)
        begin
            fail(m);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        exp_q.push_back(e);
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
    endtask

    // Spaced ticks, so a counter that runs on clocks instead of ETUs shows up early
    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge sys_clk_i);
            etu_tick_i <= 1'b1;
            @(posedge sys_clk_i);
            etu_tick_i <= 1'b0;
            cyc(2);
        end
    endtask

    // Expects the card held in reset with supply good
    task automatic release_card(input logic [7:0] len);
        wr(`CRST_ADDR_RLEN, len);
        wr(`CRST_ADDR_SIGCTL, 8'h00);
        cyc(2);
        ticks(int'(len) - 1);
        chk(8'(card_reset_n_o), 8'h00, "reset released early");
        ticks(1);
        chk(8'(card_reset_n_o), 8'h01, "reset not released");
    endtask

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge sys_clk_i)
    begin
        if (rd_p)
        begin
            if (exp_q.size() == 0)
                fail("read data without a note");
            else
                chk(rdata_o, exp_q.pop_front(), "read data");
        end
        rd_p <= rd_i && clk_en_i;
    end

    initial
    begin
        cyc(20000);
        fail("watchdog expired");
        complete_run();
    end

    initial
    begin
        logic [7:0] lim;
        void'($urandom(59));
        fuse_thr_i <= 3'($urandom);
        cyc(4);
        resetn_i <= 1'b1;
        chk(8'(card_reset_n_o), 8'h00, "pin after reset");
        rd(`CRST_ADDR_INITIAL_CHAR_TIMEOUT_VALUE, 8'h00);
        rd(`CRST_ADDR_RLEN, 8'h70);
        rd(`CRST_ADDR_FLTCTL, 8'h00);
        rd(16'hFE30, 8'h00);
        rd(`CRST_ADDR_IRQCLR, 8'h00);
        chk(8'(fault_threshold_o), 8'(fuse_thr_i), "fuse threshold");
        $display("test reset values done");
        card_supply_good_i <= 1'b1;
        cyc(5);
        ticks(8'h6F);
        chk(8'(card_reset_n_o), 8'h00, "default delay short");
        ticks(1);
        chk(8'(card_reset_n_o), 8'h01, "default delay long");
        rd(`CRST_ADDR_SUPCTL, 8'h08);
        $display("test default release done");
        wr(`CRST_ADDR_SIGCTL, 8'h80);
        cyc(3);
        chk(8'(card_reset_n_o), 8'h00, "hold ignored");
        card_supply_good_i <= 1'b0;
        cyc(4);
        card_supply_good_i <= 1'b1;
        cyc(5);
        ticks(3);
        chk(8'(card_reset_n_o), 8'h00, "held card released");
        release_card(8'(2 + $urandom % 8));
        $display("test hold release done");
        wr(`CRST_ADDR_SIGCTL, 8'h80);
        card_supply_good_i <= 1'b0;
        wr(`CRST_ADDR_RLEN, 8'h00);
        wr(`CRST_ADDR_SIGCTL, 8'h00);
        cyc(3);
        chk(8'(card_reset_n_o), 8'h00, "release without supply");
        card_supply_good_i <= 1'b1;
        cyc(6);
        chk(8'(card_reset_n_o), 8'h01, "zero length release");
        $display("test zero length done");
        lim = 8'(1 + $urandom % 5);
        wr(`CRST_ADDR_SIGCTL, 8'h80);
        wr(`CRST_ADDR_BYTECTL, 8'h40);
        wr(`CRST_ADDR_IRQEN, 8'h01);
        wr(`CRST_ADDR_INITIAL_CHAR_TIMEOUT_VALUE, lim);
        clk_en_i <= 1'b0;
        wr(`CRST_ADDR_INITIAL_CHAR_TIMEOUT_VALUE, 8'hA5);
        clk_en_i <= 1'b1;
        rd(`CRST_ADDR_INITIAL_CHAR_TIMEOUT_VALUE, lim);
        card_delay <= lim;
        release_card(8'h02);
        ticks(int'(lim) + 2);
        rd(`CRST_ADDR_IRQSTAT, 8'h00);
        wr(`CRST_ADDR_SIGCTL, 8'h80);
        card_mute <= 1'b1;
        release_card(8'h02);
        ticks(int'(lim));
        rd(`CRST_ADDR_IRQSTAT, 8'h00);
        ticks(1);
        rd(`CRST_ADDR_IRQSTAT, 8'h01);
        chk(8'(irq_o), 8'h01, "timeout irq");
        wr(`CRST_ADDR_IRQEN, 8'h00);
        cyc(2);
        chk(8'(irq_o), 8'h00, "masked irq");
        wr(`CRST_ADDR_IRQCLR, 8'h01);
        rd(`CRST_ADDR_IRQSTAT, 8'h00);
        $display("test first character timer done");
        wr(`CRST_ADDR_IRQEN, 8'h02);
        // Zero length re-releases the card after each fault, so every pass sees a live card
        wr(`CRST_ADDR_RLEN, 8'h00);
        for (int s = 0; s < 8; s++)
        begin
            wr(`CRST_ADDR_FLTCTL, 8'h40 | 8'(s));
            cyc(3);
            chk(8'(fault_threshold_o), 8'(s), "selected threshold");
            vdd_below_i <= 8'hFF << (s + 1);
            cyc(5);
            chk(8'(card_deactivate_o), 8'h00, "fault above threshold");
            chk(8'(card_reset_n_o), 8'h01, "card dropped above threshold");
            vdd_below_i <= 8'hFF << s;
            cyc(5);
            chk(8'(card_deactivate_o), 8'h01, "no deactivation");
            chk(8'(card_reset_n_o), 8'h00, "card not reset on fault");
            vdd_below_i <= 8'h00;
            cyc(5);
        end
        rd(`CRST_ADDR_IRQSTAT, 8'h02);
        chk(8'(irq_o), 8'h01, "fault irq");
        wr(`CRST_ADDR_FLTCTL, 8'(fuse_thr_i ^ 3'h7));
        cyc(3);
        chk(8'(fault_threshold_o), 8'(fuse_thr_i), "override clear");
        wr(`CRST_ADDR_FLTCTL, 8'hFF);
        rd(`CRST_ADDR_FLTCTL, 8'h67);
        vdd_below_i <= 8'hFF;
        cyc(5);
        chk(8'(card_deactivate_o), 8'h00, "disabled fault");
        wr(`CRST_ADDR_FLTCTL, 8'h00);
        cyc(5);
        chk(8'(card_deactivate_o), 8'h01, "default threshold fault");
        rd(`CRST_ADDR_SUPCTL, 8'h28);
        $display("test supply fault done");
        cyc(3);
        complete_run();
    end
endmodule
